// [hdl/ssbr_pkg.sv]
// Shared constants, field positions and types for the serial status block
package ssbr_pkg;

	// Register bus geometry
	localparam int unsigned SSBR_ADDR_W = 8;
	localparam int unsigned SSBR_DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] SSBR_OFS_STATUS   = 8'h00;
	localparam logic [7:0] SSBR_OFS_CTRL     = 8'h04;
	localparam logic [7:0] SSBR_OFS_DIVIDER  = 8'h08;
	localparam logic [7:0] SSBR_OFS_TXDATA   = 8'h0C;
	localparam logic [7:0] SSBR_OFS_RXDATA   = 8'h10;
	localparam logic [7:0] SSBR_OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] SSBR_OFS_IRQ_MASK = 8'h18;

	// Status register bit positions
	localparam int unsigned SSBR_BIT_MULTIPROC_BIT_TO_SEND = 0;
	localparam int unsigned SSBR_BIT_MULTIPROC_BIT_RECEIVED = 1;
	localparam int unsigned SSBR_BIT_TRANSMIT_END_FLAG = 2;
	localparam int unsigned SSBR_BIT_PER  = 3;
	localparam int unsigned SSBR_BIT_RDRF = 6;
	localparam int unsigned SSBR_BIT_TRANSMIT_BUFFER_EMPTY_FLAG = 7;

	// Interrupt status and mask bit positions
	localparam int unsigned SSBR_IRQ_TRANSMIT_END_FLAG = 0;
	localparam int unsigned SSBR_IRQ_RXF  = 1;
	localparam int unsigned SSBR_IRQ_PER  = 2;
	localparam int unsigned SSBR_IRQ_W    = 3;

	// Values after reset
	localparam logic       SSBR_RST_TRANSMIT_END_FLAG    = 1'b1;
	localparam logic       SSBR_RST_TRANSMIT_BUFFER_EMPTY_FLAG    = 1'b1;
	localparam logic       SSBR_RST_FLAG    = 1'b0;
	localparam logic [7:0] SSBR_RST_DIVIDER = 8'hFF;
	localparam logic [5:0] SSBR_RST_CTRL    = 6'h00;

	// Frame geometry: eight data bits, optional parity, optional MP bit
	localparam int unsigned SSBR_DATA_BITS = 8;
	localparam int unsigned SSBR_FRAME_MAX = 10;
	localparam int unsigned SSBR_CNT_W     = 16;

	// AXI response codes
	localparam logic [1:0] SSBR_RESP_OKAY   = 2'b00;
	localparam logic [1:0] SSBR_RESP_SLVERR = 2'b10;

	// Control register fields, bit 0 upward: te, re, par_en, mp_en, cks
	typedef struct packed {
		logic [1:0] cks;
		logic       mp_en;
		logic       par_en;
		logic       re;
		logic       te;
	} ssbr_ctrl_t;

	// Serial engine states, Gray along idle, low, high, gap
	typedef enum logic [1:0] {
		SSBR_IDLE = 2'b00,
		SSBR_LOW  = 2'b01,
		SSBR_HIGH = 2'b11,
		SSBR_GAP  = 2'b10
	} ssbr_state_t;

endpackage

// [hdl/ssbr_top.sv]
// Serial status flags and clocked synchronous bit-rate engine, AXI4-Lite
// What this block does
// - Parity error flag, status bit 3, sets on a received parity error.
// - Parity error flag clears only by writing 0 after reading it 1.
// - Transmit end flag, bit 2, read-only, resets 1, held while TE 0.
// - Transmit end sets as the last bit starts out if buffer-empty flag is 1.
// - Transmit end clears when buffer-empty flag is cleared after read 1.
// - Transmit end also clears when transmit data register is written.
// - Bit 1 is read-only copy of last received MP bit, resets 0.
// - Received MP bit keeps its value while receive enable is 0.
// - Bit 0 read/write, resets 0, appended as transmitted MP bit.
// - Synchronous rate comes from clock select n and 8-bit divider N.
// - Divider 0 gives top rate without back-to-back continuous transfer.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module ssbr_top (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_reset,
	input  wire logic [ssbr_pkg::SSBR_ADDR_W-1:0] i_awaddr,
	input  wire logic                           i_awvalid,
	output logic                                o_awready,
	input  wire logic [ssbr_pkg::SSBR_DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                     i_wstrb,
	input  wire logic                           i_wvalid,
	output logic                                o_wready,
	output logic [1:0]                          o_bresp,
	output logic                                o_bvalid,
	input  wire logic                           i_bready,
	input  wire logic [ssbr_pkg::SSBR_ADDR_W-1:0] i_araddr,
	input  wire logic                           i_arvalid,
	output logic                                o_arready,
	output logic [ssbr_pkg::SSBR_DATA_W-1:0]      o_rdata,
	output logic [1:0]                          o_rresp,
	output logic                                o_rvalid,
	input  wire logic                           i_rready,
	output logic                                o_irq,
	output logic                                o_sclk,
	output logic                                o_txd,
	input  wire logic                           i_rxd
);
	import ssbr_pkg::*;

	// Half serial period minus one: 2*(N+1)*4^n cycles per half
	function automatic logic [SSBR_CNT_W-1:0] half_period(
		input logic [1:0] cks,
		input logic [7:0] div
	);
		logic [SSBR_CNT_W:0] full;
		full = ({9'h000, div} + 17'h00001) << ({2'b00, cks, 1'b0} + 4'h1);
		half_period = SSBR_CNT_W'(full - 17'h00001);
	endfunction

	// Frame length in bits for a control setting
	function automatic logic [3:0] frame_len(input ssbr_ctrl_t c);
		frame_len = 4'(SSBR_DATA_BITS) + {3'b000, c.par_en}
			+ {3'b000, c.mp_en};
	endfunction

	// Transmit frame: data, then even parity, then MP bit; spare bits high
	function automatic logic [SSBR_FRAME_MAX-1:0] tx_frame(
		input ssbr_ctrl_t c,
		input logic [7:0] data,
		input logic       mpb
	);
		logic [1:0] tail;
		tail = 2'b11;
		if (c.par_en && c.mp_en) begin
			tail = {mpb, ^data};
		end else if (c.par_en) begin
			tail = {1'b1, ^data};
		end else if (c.mp_en) begin
			tail = {1'b1, mpb};
		end
		tx_frame = {tail, data};
	endfunction

	// Register state
	ssbr_ctrl_t                 ctrl_ff;
	logic [7:0]                 divider_ff;
	logic [7:0]                 txdata_ff;
	logic [7:0]                 rxdata_ff;
	logic                       per_ff, transmit_end_flag_ff, multiproc_bit_received_ff, multiproc_bit_to_send_ff;
	logic                       transmit_buffer_empty_flag_ff, rdrf_ff;
	logic                       per_seen_ff, transmit_buffer_empty_flag_seen_ff;
	logic [SSBR_IRQ_W-1:0]      irq_stat_ff, irq_mask_ff;

	// Bus state
	logic                       aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [7:0]                 awaddr_ff;
	logic [SSBR_DATA_W-1:0]     wdata_ff, rdata_ff;
	logic [3:0]                 wstrb_ff;
	logic [1:0]                 bresp_ff, rresp_ff;

	// Serial engine state
	ssbr_state_t                state_ff;
	ssbr_ctrl_t                 cfg_ff;
	logic [SSBR_CNT_W-1:0]      cnt_ff, half_ff;
	logic [3:0]                 idx_ff, nbits_ff;
	logic [SSBR_FRAME_MAX-1:0]  tx_sh_ff, rx_sh_ff;
	logic                       tx_act_ff, rx_act_ff, sclk_ff, txd_ff;
	logic                       zero_div_ff;
	logic                       rxd_meta_ff, rxd_ff;

	// Decoded strobes
	logic                       wr_fire, rd_fire, wr_ok, wr_lane0;
	logic                       wr_status, wr_ctrl, wr_div, wr_tx;
	logic                       wr_istat, wr_imask, rd_status, rd_rx;
	logic                       start_tx, start_rx, bit_end, last_bit;
	logic                       tx_last, rx_done, rx_perr;
	logic [7:0]                 rd_addr;
	logic [7:0]                 status_byte;
	logic [SSBR_IRQ_W-1:0]      irq_evt;

	// Write path: address and data taken in either order, answer after both
	assign o_awready = !aw_held_ff && !bvalid_ff;
	assign o_wready  = !w_held_ff && !bvalid_ff;
	assign wr_fire   = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_ok     = awaddr_ff[1:0] == 2'b00 && awaddr_ff <= SSBR_OFS_IRQ_MASK;
	assign wr_lane0  = wr_fire && wr_ok && wstrb_ff[0];
	assign wr_status = wr_lane0 && awaddr_ff == SSBR_OFS_STATUS;
	assign wr_ctrl   = wr_lane0 && awaddr_ff == SSBR_OFS_CTRL;
	assign wr_div    = wr_lane0 && awaddr_ff == SSBR_OFS_DIVIDER;
	assign wr_tx     = wr_lane0 && awaddr_ff == SSBR_OFS_TXDATA;
	assign wr_istat  = wr_lane0 && awaddr_ff == SSBR_OFS_IRQ_STAT;
	assign wr_imask  = wr_lane0 && awaddr_ff == SSBR_OFS_IRQ_MASK;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bresp_ff   <= SSBR_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= i_wdata;
				wstrb_ff  <= i_wstrb;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? SSBR_RESP_OKAY : SSBR_RESP_SLVERR;
			end else if (bvalid_ff && i_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign o_bvalid = bvalid_ff;
	assign o_bresp  = bresp_ff;

	// Read path: one read under way, data registered with the answer
	assign o_arready = !rvalid_ff;
	assign rd_fire   = i_arvalid && o_arready;
	assign rd_addr   = i_araddr;
	assign rd_status = rd_fire && rd_addr == SSBR_OFS_STATUS;
	assign rd_rx     = rd_fire && rd_addr == SSBR_OFS_RXDATA;
	assign status_byte = {transmit_buffer_empty_flag_ff, rdrf_ff, 2'b00,
		per_ff, transmit_end_flag_ff, multiproc_bit_received_ff, multiproc_bit_to_send_ff};

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= SSBR_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= SSBR_RESP_OKAY;
			case (rd_addr)
				SSBR_OFS_STATUS:   rdata_ff <= {24'h000000, status_byte};
				SSBR_OFS_CTRL:     rdata_ff <= {26'h0000000, ctrl_ff};
				SSBR_OFS_DIVIDER:  rdata_ff <= {24'h000000, divider_ff};
				SSBR_OFS_TXDATA:   rdata_ff <= {24'h000000, txdata_ff};
				SSBR_OFS_RXDATA:   rdata_ff <= {24'h000000, rxdata_ff};
				SSBR_OFS_IRQ_STAT: rdata_ff <= {29'h00000000, irq_stat_ff};
				SSBR_OFS_IRQ_MASK: rdata_ff <= {29'h00000000, irq_mask_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= SSBR_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && i_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign o_rvalid = rvalid_ff;
	assign o_rdata  = rdata_ff;
	assign o_rresp  = rresp_ff;

	// Plain software registers; control, divider, data, MP bit to send
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctrl_ff     <= SSBR_RST_CTRL;
			divider_ff  <= SSBR_RST_DIVIDER;
			txdata_ff   <= 8'h00;
			multiproc_bit_to_send_ff     <= SSBR_RST_FLAG;
			irq_mask_ff <= 3'h0;
		end else begin
			if (wr_ctrl) ctrl_ff <= wdata_ff[5:0];
			if (wr_div) divider_ff <= wdata_ff[7:0];
			if (wr_tx) txdata_ff <= wdata_ff[7:0];
			if (wr_status) multiproc_bit_to_send_ff <= wdata_ff[SSBR_BIT_MULTIPROC_BIT_TO_SEND];
			if (wr_imask) irq_mask_ff <= wdata_ff[SSBR_IRQ_W-1:0];
		end
	end

	// Read-as-one tracking; a zero write only clears a flag seen as one
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			per_seen_ff  <= 1'b0;
			transmit_buffer_empty_flag_seen_ff <= 1'b0;
		end else begin
			if (!per_ff) per_seen_ff <= 1'b0;
			else if (rd_status) per_seen_ff <= 1'b1;
			if (!transmit_buffer_empty_flag_ff) transmit_buffer_empty_flag_seen_ff <= 1'b0;
			else if (rd_status) transmit_buffer_empty_flag_seen_ff <= 1'b1;
		end
	end

	// Parity error flag; hardware set wins over a same-cycle clear
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			per_ff <= SSBR_RST_FLAG;
		end else if (rx_perr) begin
			per_ff <= 1'b1;
		end else if (wr_status && !wdata_ff[SSBR_BIT_PER] && per_seen_ff) begin
			per_ff <= 1'b0;
		end
	end

	// Buffer-empty flag: set on load into the shifter, cleared by software
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			transmit_buffer_empty_flag_ff <= SSBR_RST_TRANSMIT_BUFFER_EMPTY_FLAG;
		end else if (start_tx) begin
			transmit_buffer_empty_flag_ff <= 1'b1;
		end else if (wr_tx) begin
			transmit_buffer_empty_flag_ff <= 1'b0;
		end else if (wr_status && !wdata_ff[SSBR_BIT_TRANSMIT_BUFFER_EMPTY_FLAG] && transmit_buffer_empty_flag_seen_ff) begin
			transmit_buffer_empty_flag_ff <= 1'b0;
		end
	end

	// Transmit end: held while transmit disabled, set at last bit
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			transmit_end_flag_ff <= SSBR_RST_TRANSMIT_END_FLAG;
		end else if (!ctrl_ff.te) begin
			transmit_end_flag_ff <= 1'b1;
		end else if (tx_last && transmit_buffer_empty_flag_ff) begin
			transmit_end_flag_ff <= 1'b1;
		end else if (wr_tx) begin
			transmit_end_flag_ff <= 1'b0;
		end else if (wr_status && !wdata_ff[SSBR_BIT_TRANSMIT_BUFFER_EMPTY_FLAG] && transmit_buffer_empty_flag_seen_ff) begin
			transmit_end_flag_ff <= 1'b0;
		end
	end

	// Receive buffer, full flag and received MP bit
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rxdata_ff <= 8'h00;
			rdrf_ff   <= SSBR_RST_FLAG;
			multiproc_bit_received_ff   <= SSBR_RST_FLAG;
		end else begin
			if (rx_done) begin
				rxdata_ff <= rx_sh_ff[7:0];
				rdrf_ff   <= 1'b1;
			end else if (rd_rx) begin
				rdrf_ff <= 1'b0;
			end
			// Frozen while receive is off, so a late frame cannot move it
			if (rx_done && cfg_ff.mp_en && ctrl_ff.re) begin
				multiproc_bit_received_ff <= cfg_ff.par_en ? rx_sh_ff[9] : rx_sh_ff[8];
			end
		end
	end

	// Interrupt status, write one to clear, set wins
	assign irq_evt = {rx_perr, rx_done, tx_last && transmit_buffer_empty_flag_ff};
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			irq_stat_ff <= 3'h0;
		end else begin
			irq_stat_ff <= irq_evt
				| (irq_stat_ff & ~(wr_istat ? wdata_ff[2:0] : 3'h0));
		end
	end
	assign o_irq = |(irq_stat_ff & irq_mask_ff);

	// Receive pin synchroniser; only the second stage is read
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rxd_meta_ff <= 1'b1;
			rxd_ff      <= 1'b1;
		end else begin
			rxd_meta_ff <= i_rxd;
			rxd_ff      <= rxd_meta_ff;
		end
	end

	// Frame control terms
	assign start_tx = state_ff == SSBR_IDLE && ctrl_ff.te && !transmit_buffer_empty_flag_ff;
	assign start_rx = state_ff == SSBR_IDLE && ctrl_ff.re && !rdrf_ff;
	assign bit_end  = state_ff == SSBR_HIGH && cnt_ff == '0;
	assign last_bit = idx_ff == nbits_ff - 4'h1;
	assign tx_last  = bit_end && !last_bit && tx_act_ff
		&& idx_ff + 4'h1 == nbits_ff - 4'h1;
	assign rx_done  = bit_end && last_bit && rx_act_ff;
	assign rx_perr  = rx_done && cfg_ff.par_en && (^rx_sh_ff[8:0]);

	// Serial engine: clock idles high, data out on fall, sampled on rise
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_ff    <= SSBR_IDLE;
			cfg_ff      <= SSBR_RST_CTRL;
			cnt_ff      <= '0;
			half_ff     <= '0;
			idx_ff      <= 4'h0;
			nbits_ff    <= 4'h0;
			tx_sh_ff    <= '1;
			rx_sh_ff    <= '0;
			tx_act_ff   <= 1'b0;
			rx_act_ff   <= 1'b0;
			sclk_ff     <= 1'b1;
			txd_ff      <= 1'b1;
			zero_div_ff <= 1'b0;
		end else begin
			case (state_ff)
				SSBR_IDLE: begin
					if (start_tx || start_rx) begin
						state_ff    <= SSBR_LOW;
						cfg_ff      <= ctrl_ff;
						half_ff     <= half_period(ctrl_ff.cks, divider_ff);
						cnt_ff      <= half_period(ctrl_ff.cks, divider_ff);
						zero_div_ff <= divider_ff == 8'h00;
						nbits_ff    <= frame_len(ctrl_ff);
						idx_ff      <= 4'h0;
						tx_sh_ff    <= start_tx
							? tx_frame(ctrl_ff, txdata_ff, multiproc_bit_to_send_ff) : '1;
						txd_ff      <= start_tx ? txdata_ff[0] : 1'b1;
						tx_act_ff   <= start_tx;
						rx_act_ff   <= start_rx;
						sclk_ff     <= 1'b0;
					end
				end
				SSBR_LOW: begin
					if (cnt_ff == '0) begin
						state_ff         <= SSBR_HIGH;
						sclk_ff          <= 1'b1;
						cnt_ff           <= half_ff;
						rx_sh_ff[idx_ff] <= rxd_ff;
					end else begin
						cnt_ff <= cnt_ff - 1'b1;
					end
				end
				SSBR_HIGH: begin
					if (cnt_ff != '0) begin
						cnt_ff <= cnt_ff - 1'b1;
					end else if (last_bit) begin
						// Top rate needs a rest between frames
						state_ff <= zero_div_ff ? SSBR_GAP : SSBR_IDLE;
						cnt_ff   <= half_ff;
						txd_ff   <= 1'b1;
					end else begin
						state_ff <= SSBR_LOW;
						sclk_ff  <= 1'b0;
						cnt_ff   <= half_ff;
						idx_ff   <= idx_ff + 4'h1;
						txd_ff   <= tx_sh_ff[idx_ff + 4'h1];
					end
				end
				SSBR_GAP: begin
					if (cnt_ff == '0) begin
						state_ff <= SSBR_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 1'b1;
					end
				end
				default: begin
					state_ff <= SSBR_IDLE;
				end
			endcase
		end
	end
	assign o_sclk = sclk_ff;
	assign o_txd  = txd_ff;

endmodule // ssbr_top

// [testbench/ssbr_checker.sv]
// Port-level assertions for the serial status block
`timescale 1ns/1ns
module ssbr_checker (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic o_irq,
	input wire logic o_sclk,
	input wire logic o_txd
);
	import ssbr_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	// Write answer lands two edges after both channels are taken
	property p_wr_resp;
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("late write answer");
	property p_rd_resp;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("late read answer");
	property p_b_drop;
		o_bvalid && i_bready |=> !o_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
	property p_r_drop;
		o_rvalid && i_rready |=> !o_rvalid;
	endproperty
	a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
	// Only one transfer of each kind in flight
	property p_ar_block;
		o_rvalid |-> !o_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read overlap");
	property p_aw_block;
		o_bvalid |-> !o_awready && !o_wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write overlap");
	// Data holds steady while the serial clock stays low
	property p_txd_hold;
		!o_sclk && !$past(o_sclk) |-> $stable(o_txd);
	endproperty
	a_txd_hold: assert property (p_txd_hold) else $error("txd moved");
	// Half period is never shorter than two cycles
	property p_sclk_min;
		$changed(o_sclk) |=> $stable(o_sclk);
	endproperty
	a_sclk_min: assert property (p_sclk_min) else $error("short half");
	property p_rst;
		disable iff (1'b0)
		i_reset |=> o_sclk && o_txd && !o_bvalid && !o_rvalid && !o_irq;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	c_write: cover property (o_bvalid && i_bready);
	c_read: cover property (o_rvalid && i_rready);
	c_sclk: cover property ($fell(o_sclk));
	c_irq: cover property ($rose(o_irq));
endmodule // ssbr_checker

bind ssbr_top ssbr_checker chk_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
	.o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
	.i_rready(i_rready), .o_irq(o_irq), .o_sclk(o_sclk), .o_txd(o_txd));

// [testbench/ssbr_remote.sv]
// Remote serial node: drives a frame on rxd, captures txd
`timescale 1ns/1ns
module ssbr_remote (
	input  wire logic       i_reset,
	input  wire logic       i_sclk,
	input  wire logic       i_txd,
	input  wire logic [9:0] i_frame,
	output logic            o_rxd,
	output logic [9:0]      o_cap
);
	int   tx_idx;
	int   rx_idx;
	logic drv;
	// Next bit goes out at each falling serial clock, LSB first
	always @(negedge i_sclk or posedge i_reset) begin
		if (i_reset) begin
			tx_idx <= 0;
			drv    <= 1'b1;
		end else begin
			drv    <= i_frame[tx_idx];
			tx_idx <= (tx_idx == 9) ? 0 : tx_idx + 1;
		end
	end
	// Captured at the rising edge, where the receiver also samples
	always @(posedge i_sclk or posedge i_reset) begin
		if (i_reset) begin
			rx_idx <= 0;
		end else begin
			o_cap[rx_idx] <= i_txd;
			rx_idx        <= (rx_idx == 9) ? 0 : rx_idx + 1;
		end
	end
	// Released line flips so a stale bit cannot pass as valid
	assign o_rxd = (tx_idx == 0 && rx_idx == 0) ? ~drv : drv;
endmodule // ssbr_remote

// [testbench/tb.sv]
// Self-checking bench for the serial status block
`timescale 1ns/1ns
module tb;
	import ssbr_pkg::*;
	logic        clk = 1'b0, rst = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq, sclk, txd;
	logic        rxd;
	logic [1:0]  bresp, rresp, r;
	logic [9:0]  frame = 10'h000, cap;
	logic [31:0] d;
	int          fails = 0, comparisons = 0, c;

	ssbr_top uut (.i_clk_sys(clk), .i_reset(rst), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq),
		.o_sclk(sclk), .o_txd(txd), .i_rxd(rxd));
	ssbr_remote node (.i_reset(rst), .i_sclk(sclk), .i_txd(txd),
		.i_frame(frame), .o_rxd(rxd), .o_cap(cap));

	// 25 MHz system clock
	initial forever #20 clk = ~clk;

	task automatic test_done();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic timeout();
		fails++;
		test_done();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Handshakes judged at the falling edge, released after the rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ha, hw, hb;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			if (bvalid) r = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic rd(input logic [7:0] a);
		logic ha, hr;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = arvalid & arready;
			hr = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			if (hr) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		for (int n = 0; n < 400; n++) begin
			rd(a);
			if ((d & m) === m) return;
		end
		timeout();
	endtask

	task automatic t_reset();
		rchk(SSBR_OFS_STATUS, 32'h84);
		rchk(SSBR_OFS_CTRL, 32'h00);
		rchk(SSBR_OFS_DIVIDER, 32'hFF);
		rchk(SSBR_OFS_IRQ_MASK, 32'h00);
		rd(8'h40);
		chk(r, SSBR_RESP_SLVERR);
		wr(8'h40, 32'h0000_0000);
		chk(r, SSBR_RESP_SLVERR);
		wr(SSBR_OFS_STATUS, 32'h81);
		chk(r, SSBR_RESP_OKAY);
		rchk(SSBR_OFS_STATUS, 32'h85);
		wr(SSBR_OFS_STATUS, 32'h80);
		rchk(SSBR_OFS_STATUS, 32'h84);
	endtask

	// Received frame with bad parity and MP bit set
	task automatic t_rx();
		frame <= 10'h33C;
		wr(SSBR_OFS_DIVIDER, 32'h02);
		wr(SSBR_OFS_IRQ_MASK, 32'h02);
		wr(SSBR_OFS_CTRL, 32'h0E);
		for (c = 0; c < 2000 && irq !== 1'b1; c++) @(negedge clk);
		if (c == 2000) timeout();
		wr(SSBR_OFS_CTRL, 32'h0C);
		wr(SSBR_OFS_STATUS, 32'h80);
		rchk(SSBR_OFS_STATUS, 32'hCE);
		wr(SSBR_OFS_STATUS, 32'h80);
		rchk(SSBR_OFS_STATUS, 32'hC6);
		rchk(SSBR_OFS_RXDATA, 32'h3C);
		rchk(SSBR_OFS_STATUS, 32'h86);
		wr(SSBR_OFS_IRQ_MASK, 32'h00);
		chk(irq, 1'b0);
		wr(SSBR_OFS_IRQ_MASK, 32'h02);
		chk(irq, 1'b1);
		wr(SSBR_OFS_IRQ_STAT, 32'h07);
		chk(irq, 1'b0);
	endtask

	// Sent frame at n 1, N 2: half period 24 cycles
	task automatic t_tx();
		wr(SSBR_OFS_CTRL, 32'h1D);
		wr(SSBR_OFS_STATUS, 32'h81);
		wr(SSBR_OFS_TXDATA, 32'hA5);
		rchk(SSBR_OFS_STATUS, 32'h83);
		for (c = 0; c < 200 && sclk !== 1'b1; c++) @(negedge clk);
		for (c = 0; c < 200 && sclk !== 1'b0; c++) @(negedge clk);
		for (c = 0; c < 200 && sclk === 1'b0; c++) @(negedge clk);
		chk(c, 24);
		poll(SSBR_OFS_STATUS, 32'h04);
		repeat (48) @(negedge clk);
		chk(cap, 10'h2A5);
		rchk(SSBR_OFS_STATUS, 32'h87);
	endtask

	task automatic t_transmit_buffer_empty_flag();
		wr(SSBR_OFS_STATUS, 32'h01);
		rchk(SSBR_OFS_STATUS, 32'h83);
		poll(SSBR_OFS_STATUS, 32'h04);
		repeat (48) @(negedge clk);
		wr(SSBR_OFS_CTRL, 32'h1C);
		wr(SSBR_OFS_TXDATA, 32'h11);
		rchk(SSBR_OFS_STATUS, 32'h07);
	endtask

	// Divider 0: a rest of one half period follows each frame
	task automatic t_gap();
		int mx;
		mx = 0;
		wr(SSBR_OFS_DIVIDER, 32'h00);
		wr(SSBR_OFS_CTRL, 32'h01);
		wr(SSBR_OFS_TXDATA, 32'h22);
		for (c = 0; c < 200 && sclk !== 1'b0; c++) @(negedge clk);
		// Eight high halves always include the one between the frames
		for (int k = 0; k < 8; k++) begin
			for (c = 0; c < 200 && sclk !== 1'b1; c++) @(negedge clk);
			for (c = 0; c < 200 && sclk === 1'b1; c++) @(negedge clk);
			if (c > mx) mx = c;
		end
		chk(mx, 5);
	endtask

	// Reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rx();
		t_tx();
		t_transmit_buffer_empty_flag();
		t_gap();
		test_done();
	end
endmodule // tb
